// ### core/dio_port_pkg.sv
// Register map and field layout of the eight-line digital port
package dio_port_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          LINE_W          = 8;
    localparam int          HALF_W          = 4;
    // Byte addresses
    localparam logic [7:0]  OFF_LINE_DATA   = 8'h1C;
    localparam logic [7:0]  OFF_PORT_CTRL   = 8'h20;
    // Port control fields
    localparam int          CTRL_A_EN_BIT   = 0;
    localparam int          CTRL_B_EN_BIT   = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h0;
    localparam logic [15:0] PATTERN_RESET   = 16'h0000;
    localparam int          PORT_A_LSB      = 0;
    localparam int          PORT_B_LSB      = 4;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : dio_port_pkg

// ### core/line_sync.sv
// Two-flop synchroniser for the connector lines
`timescale 1ns/1ps
module line_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] lines_async,
    output logic      [WIDTH-1:0] lines_sync
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_r     <= '0;
            lines_sync <= '0;
        end else begin
            meta_r     <= lines_async;
            lines_sync <= meta_r;
        end
    end
endmodule : line_sync

// ### core/eight_line_digital_io_port.sv
// Eight-line digital port with AXI4-Lite register access
//
// Overview of operation
// - Reading the input register returns the live pin levels, not the stored pattern.
// - Input bits 7-4 are port B lines, 3-0 port A, 15-8 meaningless.
// - Write at the input offset loads write-only pattern; reads stay pin levels.
// - One shared pattern register feeds both four-line ports when enabled.
// - Pattern bits 7-4 drive port B only while port B enable is set.
// - Pattern bits 3-0 drive port A only while port A enable is set.
// - Writing zero to the control register leaves both ports as inputs.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module eight_line_digital_io_port
    import dio_port_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Connector lines
    input  wire logic [HALF_W-1:0] port_a_lines,
    output logic      [HALF_W-1:0] port_a_lines_drv,
    output logic      [HALF_W-1:0] port_a_lines_oe_n,
    input  wire logic [HALF_W-1:0] port_b_lines,
    output logic      [HALF_W-1:0] port_b_lines_drv,
    output logic      [HALF_W-1:0] port_b_lines_oe_n
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_r;
    logic rst_n_r;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ****************************************
    // Pin sampling
    // ****************************************
    logic [LINE_W-1:0] pins_sync;
    line_sync #(.WIDTH(LINE_W)) u_sync (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n_r),
        .lines_async ({port_b_lines, port_a_lines}),
        .lines_sync  (pins_sync)
    );

    // ****************************************
    // Register decode
    // ****************************************
    // Word select: bit 0 line word, bit 1 port control, none if unmapped
    function automatic logic [1:0] reg_select(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] aligned;
        aligned = {addr[ADDR_W-1:2], 2'b00};
        if (aligned == OFF_LINE_DATA) begin
            reg_select = 2'h1;
        end else if (aligned == OFF_PORT_CTRL) begin
            reg_select = 2'h2;
        end else begin
            reg_select = 2'h0;
        end
    endfunction : reg_select

    // ****************************************
    // Write channel
    // ****************************************
    logic [ADDR_W-1:0] awaddr_r;
    logic              aw_held_r;
    logic [DATA_W-1:0] wdata_r;
    logic [3:0]        wstrb_r;
    logic              w_held_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic [15:0]       pattern_r;
    logic [1:0]        ctrl_r;

    wire       aw_take   = s_axi_awvalid && s_axi_awready;
    wire       w_take    = s_axi_wvalid && s_axi_wready;
    wire       wr_go     = aw_held_r && w_held_r && !bvalid_r;
    wire [1:0] wr_sel    = reg_select(awaddr_r);
    wire       wr_pat    = wr_go && wr_sel[0];
    wire       wr_ctrl   = wr_go && wr_sel[1];
    wire       wr_mapped = wr_pat || wr_ctrl;

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    // Address held until the pair commits
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            awaddr_r  <= '0;
            aw_held_r <= 1'b0;
        end else if (aw_take) begin
            awaddr_r  <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
            aw_held_r <= 1'b1;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    // Data held until the pair commits
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wdata_r  <= '0;
            wstrb_r  <= '0;
            w_held_r <= 1'b0;
        end else if (w_take) begin
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
            w_held_r <= 1'b1;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // One response per committed write
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ****************************************
    // Pattern and port control registers
    // ****************************************
    // Upper byte stored as written; software keeps it zero
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            pattern_r <= PATTERN_RESET;
        end else begin
            if (wr_pat && wstrb_r[0]) begin
                pattern_r[7:0] <= wdata_r[7:0];
            end
            if (wr_pat && wstrb_r[1]) begin
                pattern_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    // Enables start cleared so no line is driven before software asks
    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr_ctrl && wstrb_r[0]) begin
            ctrl_r <= wdata_r[1:0];
        end
    end

    // ****************************************
    // Line drivers
    // ****************************************
    wire en_a = ctrl_r[CTRL_A_EN_BIT];
    wire en_b = ctrl_r[CTRL_B_EN_BIT];
    // Pattern always presented; the enable alone decides what reaches a line
    assign port_a_lines_drv  = pattern_r[PORT_A_LSB +: HALF_W];
    assign port_b_lines_drv  = pattern_r[PORT_B_LSB +: HALF_W];
    assign port_a_lines_oe_n = {HALF_W{~en_a}};
    assign port_b_lines_oe_n = {HALF_W{~en_b}};

    // ****************************************
    // Read channel
    // ****************************************
    logic              rvalid_r;
    logic [DATA_W-1:0] rdata_r;
    logic [1:0]        rresp_r;

    wire [1:0]        rd_sel  = reg_select(s_axi_araddr);
    wire              rd_line = rd_sel[0];
    wire              rd_ctrl = rd_sel[1];
    // Pin levels come through the synchroniser, never from the pattern
    wire [DATA_W-1:0] rd_word = rd_line ? {24'h0, pins_sync} :
                                rd_ctrl ? {30'h0, ctrl_r} : 32'h0;

    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge clk_sys or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= (rd_line || rd_ctrl) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : eight_line_digital_io_port

// ### testbench/dio_port_props.sv
// Port rule checker
`timescale 1ns/1ps
module dio_port_props
    import dio_port_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [HALF_W-1:0] port_a_lines,
    input wire logic [HALF_W-1:0] port_b_lines,
    input wire logic [HALF_W-1:0] port_a_lines_drv,
    input wire logic [HALF_W-1:0] port_b_lines_drv,
    input wire logic [HALF_W-1:0] port_a_lines_oe_n,
    input wire logic [HALF_W-1:0] port_b_lines_oe_n
);
    wire [7:0] pins = {port_b_lines, port_a_lines};
    wire [7:0] oe_n = {port_b_lines_oe_n, port_a_lines_oe_n};
    wire [7:0] drv  = {port_b_lines_drv, port_a_lines_drv};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_A_WHOLE: assert property (port_a_lines_oe_n inside {4'h0, 4'hF}) else $error("A split");
    AST_B_WHOLE: assert property (port_b_lines_oe_n inside {4'h0, 4'hF}) else $error("B split");
    AST_OE_COMMIT: assert property (!$stable(oe_n) |-> $rose(s_axi_bvalid)) else $error("oe moved");
    AST_PAT_COMMIT: assert property (!$stable(drv) |-> $rose(s_axi_bvalid))
        else $error("pattern moved");
    AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper");
    AST_PINS: assert property ($rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_LINE_DATA &&
        $past(pins, 2) == $past(pins, 3) && $past(pins, 3) == $past(pins, 4)
        |-> s_axi_rdata[7:0] == $past(pins, 3)) else $error("pins");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rhold");
    AST_RST_OFF: assert property ($rose(rstn) |-> (oe_n == 8'hFF) [*3]) else $error("reset drive");
endmodule : dio_port_props
bind eight_line_digital_io_port dio_port_props props (.clk_sys, .rstn, .s_axi_bvalid, .s_axi_rvalid,
    .s_axi_rready, .s_axi_araddr, .s_axi_rdata, .port_a_lines, .port_b_lines, .port_a_lines_drv,
    .port_b_lines_drv, .port_a_lines_oe_n, .port_b_lines_oe_n);

// ### testbench/dio_far_side.sv
// External circuitry on the connector lines
`timescale 1ns/1ps
module dio_far_side (
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] dev_drive,
    input  wire logic [7:0] dev_oe_n,
    output logic      [7:0] lvl
);
    // Device wins where it drives
    assign lvl = (~dev_oe_n & dev_drive) | (dev_oe_n & ext_val);
endmodule : dio_far_side

// ### testbench/eight_line_digital_io_port_tb.sv
// Bench of the eight-line port
`timescale 1ns/1ps
module eight_line_digital_io_port_tb;
    import dio_port_pkg::*;
    logic        clk_sys = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_rready = 1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, ext_val = 0, lvl;
    logic [31:0] s_axi_wdata = 0, seed = 43176, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, shadow;
    logic [3:0]  port_a_lines_drv, port_a_lines_oe_n, port_b_lines_drv, port_b_lines_oe_n;
    logic [33:0] rq[$], bq[$];
    logic [15:0] pat;
    int          n_errors = 0, total_checks = 0, cycles = 0;
    eight_line_digital_io_port dut (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .port_a_lines(lvl[3:0]), .port_a_lines_drv, .port_a_lines_oe_n,
        .port_b_lines(lvl[7:4]), .port_b_lines_drv, .port_b_lines_oe_n);
    dio_far_side far (.ext_val, .dev_drive({port_b_lines_drv, port_a_lines_drv}),
        .dev_oe_n({port_b_lines_oe_n, port_a_lines_oe_n}), .lvl);
    always #2 clk_sys = ~clk_sys;
    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : xs
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            @(negedge clk_sys);
        end while (s_axi_awvalid || s_axi_wvalid);
        do @(posedge clk_sys); while (!s_axi_bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h0;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        @(posedge clk_sys);
        s_axi_rready <= 1'h1;
        do @(posedge clk_sys); while (!s_axi_rvalid);
    endtask : rd
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid) check({s_axi_bresp, 32'h0}, bq.pop_front());
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rstn <= 1'h1;
        repeat (3) @(posedge clk_sys);
        rd(OFF_PORT_CTRL, 32'h0, RESP_OKAY);
        for (int i = 1; i <= 4; i++) begin
            ext_val <= xs();
            pat = {8'h00, xs()};
            shadow = i[1:0];
            wr(OFF_LINE_DATA, {16'h0, pat}, RESP_OKAY);
            wr(OFF_PORT_CTRL, {30'h0, shadow}, RESP_OKAY);
            repeat (4) @(posedge clk_sys);
            rd(OFF_LINE_DATA, {24'h0, shadow[1] ? pat[7:4] : ext_val[7:4],
                shadow[0] ? pat[3:0] : ext_val[3:0]}, RESP_OKAY);
        end
        wr(8'h40, 32'h3, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        rd(OFF_PORT_CTRL, 32'h0, RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        complete_run();
    end
endmodule : eight_line_digital_io_port_tb
